//--- hdl/spp_pkg.sv
// Constants and types shared by the serial packet packer
// Operation
// - Startup mode opens the connection right after reset and never closes it.
// - Character modes open on first serial byte; one variant closes on inactivity.
// - DSR modes open on DSR on; only the on/off variant closes on DSR off.
// - DCD modes open on DCD on; only the on/off variant closes on DCD off.
// - Datagrams are accepted on a listen port 1 to 65535, reset to 4001.
// - A byte threshold of 1 to 1024 flushes once the count reaches it.
// - A byte threshold of 0, the reset value, disables count flushing.
// - With no marker set, every received byte is forwarded at once.
// - With the first marker set, bytes collect until the marker sequence, then flush.
// - Markers are 8-bit values; 00 means unused; both 00 disables markers.
// - A full 1K buffer flushes as one frame and clears the buffer.
// - Marker processing needs the first marker, and both characters when two set.
// - Pass-through mode, the reset choice, sends the buffer with the marker at once.
// - Plus-one and plus-two modes wait for one or two more bytes.
// - Strip mode drops the marker bytes and sends the rest.
// - An idle flush time of 0, the reset value, disables idle flushing.
// - An idle flush time of 1 to 65535 ms flushes after that much silence.
// - Inactivity 0 keeps the connection until close request or keep-alive failure.
package spp_pkg;
  // ********************************
  // Timing
  // ********************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
  // ********************************
  // Buffer
  // ********************************
  localparam logic [10:0] BUF_FULL = 11'h400;
  // ********************************
  // Register offsets
  // ********************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MARK   = 8'h04;
  localparam logic [7:0] REG_PKTLEN = 8'h08;
  localparam logic [7:0] REG_IDLE   = 8'h0C;
  localparam logic [7:0] REG_INACT  = 8'h10;
  localparam logic [7:0] REG_PORT   = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  // ********************************
  // Field positions
  // ********************************
  localparam int unsigned CTRL_CONN_LSB = 0;
  localparam int unsigned CTRL_PROC_LSB = 4;
  localparam int unsigned MARK2_LSB     = 8;
  // ********************************
  // Reset values
  // ********************************
  localparam logic [15:0] PORT_RST = 16'h0FA1;
  localparam logic [10:0] THR_RST  = 11'h000;
  localparam logic [15:0] IDLE_RST = 16'h0000;
  localparam logic [7:0]  MARK_RST = 8'h00;
  // ********************************
  // Enumerations
  // ********************************
  typedef enum logic [2:0] {
    CONN_STARTUP = 3'h0,
    CONN_CHAR    = 3'h1,
    CONN_CHAR_IN = 3'h2,
    CONN_DSR_OFF = 3'h3,
    CONN_DSR     = 3'h4,
    CONN_DCD_OFF = 3'h5,
    CONN_DCD     = 3'h6
  } spp_conn_t;
  typedef enum logic [1:0] {
    PROC_PASS  = 2'h0,
    PROC_PLUS1 = 2'h1,
    PROC_PLUS2 = 2'h2,
    PROC_STRIP = 2'h3
  } spp_proc_t;
  typedef enum logic [1:0] {
    ST_FILL = 2'b01,
    ST_SEND = 2'b10
  } spp_state_t;
endpackage

//--- hdl/spp_mark_if.sv
// Signals between the packer and its marker detector
`timescale 1ns/1ps
interface spp_mark_if;
  logic                  byte_ok;
  logic [7:0]            byte_data;
  logic [7:0]            mark1;
  logic [7:0]            mark2;
  spp_pkg::spp_proc_t    proc;
  logic                  clear;
  logic                  hit;
  logic [1:0]            strip;
  modport host (output byte_ok, byte_data, mark1, mark2, proc, clear, input hit, strip);
  modport det (input byte_ok, byte_data, mark1, mark2, proc, clear, output hit, strip);
endinterface

//--- hdl/spp_marker.sv
// Marker sequence detector with post-processing
`timescale 1ns/1ps
module spp_marker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Packer side
  spp_mark_if.det  mk
);
  typedef struct packed {
    logic       prev_m1;
    logic [1:0] pend;
  } spp_mark_st_t;

  spp_mark_st_t r;
  spp_mark_st_t next_r;
  logic         seq;

  // Sequence match and flush decision
  always_comb begin
    next_r = r;
    mk.hit = 1'b0;
    mk.strip = 2'h0;
    seq = mk.byte_ok && (mk.mark1 != 8'h00) &&
          ((mk.mark2 == 8'h00) ? (mk.byte_data == mk.mark1) :
           (r.prev_m1 && (mk.byte_data == mk.mark2)));
    if (mk.byte_ok) begin
      next_r.prev_m1 = (mk.byte_data == mk.mark1);
    end
    if (r.pend != 2'h0 && mk.byte_ok) begin
      next_r.pend = r.pend - 2'h1;
      mk.hit = (r.pend == 2'h1);
    end else if (seq) begin
      unique case (mk.proc)
        spp_pkg::PROC_PASS: mk.hit = 1'b1;
        spp_pkg::PROC_PLUS1: next_r.pend = 2'h1;
        spp_pkg::PROC_PLUS2: next_r.pend = 2'h2;
        spp_pkg::PROC_STRIP: begin
          mk.hit = 1'b1;
          mk.strip = (mk.mark2 != 8'h00) ? 2'h2 : 2'h1;
        end
      endcase
    end
    if (mk.clear) begin
      next_r = '0;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  unused_off_a: assert property (mk.mark1 == 8'h00 && r.pend == 2'h0
      |-> !mk.hit && mk.strip == 2'h0)
    else $error("marker matched with first marker unused");
  plus_wait_a: assert property (seq && r.pend == 2'h0 && mk.proc inside
      {spp_pkg::PROC_PLUS1, spp_pkg::PROC_PLUS2} |-> !mk.hit)
    else $error("plus mode flushed on the marker itself");
  strip_cnt_a: assert property (seq && r.pend == 2'h0 && mk.proc == spp_pkg::PROC_STRIP
      |-> mk.hit && mk.strip == ((mk.mark2 != 8'h00) ? 2'h2 : 2'h1))
    else $error("strip count wrong");
  plus_one_c: cover property (r.pend == 2'h1 && mk.byte_ok);
endmodule

//--- hdl/spp_packer.sv
// Serial packet packer: buffer, flush triggers, connection control
`timescale 1ns/1ps
module spp_packer #(
  parameter int unsigned TICK_CYCLES = spp_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Serial receive bytes
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  // Modem lines
  input  wire logic        i_dsr,
  input  wire logic        i_dcd,
  // Network side
  input  wire logic        i_close_req,
  input  wire logic        i_keepalive_fail,
  input  wire logic        i_dgram_valid,
  input  wire logic [15:0] i_dgram_port,
  output logic             o_dgram_accept,
  output logic      [15:0] o_listen_port,
  output logic             o_conn_open,
  // Frame stream out
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_last,
  input  wire logic        i_tx_ready
);
  // ********************************
  // State
  // ********************************
  localparam int unsigned DW = $clog2(TICK_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

  typedef struct packed {
    spp_pkg::spp_state_t st;
    logic                ack;
    logic [31:0]         rdata;
    logic [2:0]          conn;
    spp_pkg::spp_proc_t  proc;
    logic [7:0]          mark1;
    logic [7:0]          mark2;
    logic [10:0]         thr;
    logic [15:0]         idle_ms;
    logic [15:0]         inact_ms;
    logic [15:0]         port;
    logic [10:0]         cnt;
    logic [10:0]         len;
    logic [10:0]         ptr;
    logic [15:0]         idle;
    logic [15:0]         inact;
    logic                open;
    logic [DW-1:0]       div;
    logic                tvalid;
    logic [7:0]          tdata;
    logic                tlast;
  } spp_top_t;

  localparam spp_top_t RST_VAL = '{
    st: spp_pkg::ST_FILL,
    proc: spp_pkg::PROC_PASS,
    conn: spp_pkg::CONN_STARTUP,
    mark1: spp_pkg::MARK_RST,
    mark2: spp_pkg::MARK_RST,
    thr: spp_pkg::THR_RST,
    idle_ms: spp_pkg::IDLE_RST,
    inact_ms: spp_pkg::IDLE_RST,
    port: spp_pkg::PORT_RST,
    default: '0
  };

  spp_top_t    r;
  spp_top_t    next_r;
  logic [7:0]  mem [0:1023];
  logic        tick;
  logic        accept;
  logic [10:0] cnt_n;
  logic [10:0] keep;
  logic        t_thr;
  logic        t_full;
  logic        t_none;
  logic        t_idle;
  logic        t_inact;
  logic        flush;
  logic        open_req;
  logic        close_req;
  logic        wr_go;
  logic [31:0] word;
  logic [31:0] wval;

  spp_mark_if mk ();

  // Byte-lane merge for partial writes
  function automatic logic [31:0] spp_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      spp_merge[8*b +: 8] = sel[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ********************************
  // Marker detector
  // ********************************
  assign mk.byte_ok = accept;
  assign mk.byte_data = i_rx_data;
  assign mk.mark1 = r.mark1;
  assign mk.mark2 = r.mark2;
  assign mk.proc = r.proc;
  assign mk.clear = flush;

  spp_marker u_marker (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .mk        (mk)
  );

  // ********************************
  // Outputs
  // ********************************
  assign o_wb_dat = r.rdata;
  assign o_wb_ack = r.ack;
  assign o_rx_ready = (r.st == spp_pkg::ST_FILL);
  assign o_listen_port = r.port;
  assign o_dgram_accept = i_dgram_valid && (i_dgram_port == r.port);
  assign o_conn_open = r.open;
  assign o_tx_valid = r.tvalid;
  assign o_tx_data = r.tdata;
  assign o_tx_last = r.tlast;

  // Buffer write port
  always_ff @(posedge i_clock) begin
    if (accept) begin
      mem[r.cnt[9:0]] <= i_rx_data;
    end
  end

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    next_r = r;
    // Millisecond tick divider
    tick = (r.div == DIV_LAST);
    next_r.div = tick ? '0 : r.div + 1'b1;
    accept = i_rx_valid && (r.st == spp_pkg::ST_FILL);
    cnt_n = r.cnt + {10'h000, accept};
    keep = (cnt_n > {9'h000, mk.strip}) ? cnt_n - {9'h000, mk.strip} : 11'h000;

    // Flush triggers
    t_thr = (r.thr != 11'h000) && (cnt_n != 11'h000) && (cnt_n >= r.thr);
    t_full = (cnt_n == spp_pkg::BUF_FULL);
    t_none = accept && (r.mark1 == 8'h00);
    t_idle = (r.idle_ms != 16'h0000) && (r.cnt != 11'h000) && !accept &&
             tick && (r.idle >= r.idle_ms - 16'h0001);
    flush = (r.st == spp_pkg::ST_FILL) &&
            (t_thr || t_full || t_none || t_idle || mk.hit);

    // Idle timer, held at zero while empty
    if (accept || r.cnt == 11'h000) begin
      next_r.idle = 16'h0000;
    end else if (tick && r.idle != 16'hFFFF) begin
      next_r.idle = r.idle + 16'h0001;
    end

    // Fill and send sequencing
    unique case (r.st)
      spp_pkg::ST_FILL: begin
        next_r.cnt = cnt_n;
        if (flush) begin
          next_r.cnt = 11'h000;
          next_r.idle = 16'h0000;
          next_r.len = keep;
          next_r.ptr = 11'h000;
          if (keep != 11'h000) begin
            next_r.st = spp_pkg::ST_SEND;
          end
        end
      end
      spp_pkg::ST_SEND: begin
        if (!r.tvalid || i_tx_ready) begin
          if (r.ptr < r.len) begin
            next_r.tdata = mem[r.ptr[9:0]];
            next_r.tvalid = 1'b1;
            next_r.tlast = (r.ptr == r.len - 11'h001);
            next_r.ptr = r.ptr + 11'h001;
          end else begin
            next_r.tvalid = 1'b0;
            next_r.tlast = 1'b0;
            next_r.st = spp_pkg::ST_FILL;
          end
        end
      end
    endcase

    // Inactivity timer for the character mode
    if (accept || !r.open) begin
      next_r.inact = 16'h0000;
    end else if (tick && r.inact != 16'hFFFF) begin
      next_r.inact = r.inact + 16'h0001;
    end
    t_inact = (r.inact_ms != 16'h0000) && r.open && !accept && tick &&
              (r.inact >= r.inact_ms - 16'h0001);

    // Connection open and close conditions
    open_req = 1'b0;
    close_req = 1'b0;
    unique case (spp_pkg::spp_conn_t'(r.conn))
      spp_pkg::CONN_STARTUP: open_req = 1'b1;
      spp_pkg::CONN_CHAR: begin
        open_req = accept;
        close_req = i_close_req || i_keepalive_fail;
      end
      spp_pkg::CONN_CHAR_IN: begin
        open_req = accept;
        close_req = t_inact || i_close_req || i_keepalive_fail;
      end
      spp_pkg::CONN_DSR_OFF: begin
        open_req = i_dsr;
        close_req = !i_dsr;
      end
      spp_pkg::CONN_DSR: open_req = i_dsr;
      spp_pkg::CONN_DCD_OFF: begin
        open_req = i_dcd;
        close_req = !i_dcd;
      end
      spp_pkg::CONN_DCD: open_req = i_dcd;
      default: open_req = 1'b1;
    endcase
    if (open_req) begin
      next_r.open = 1'b1;
    end else if (close_req) begin
      next_r.open = 1'b0;
    end

    // Register word at the bus address
    unique case (i_wb_adr)
      spp_pkg::REG_CTRL: begin
        word = 32'h0000_0000;
        word[spp_pkg::CTRL_CONN_LSB +: 3] = r.conn;
        word[spp_pkg::CTRL_PROC_LSB +: 2] = r.proc;
      end
      spp_pkg::REG_MARK: word = {16'h0000, r.mark2, r.mark1};
      spp_pkg::REG_PKTLEN: word = {21'h000000, r.thr};
      spp_pkg::REG_IDLE: word = {16'h0000, r.idle_ms};
      spp_pkg::REG_INACT: word = {16'h0000, r.inact_ms};
      spp_pkg::REG_PORT: word = {16'h0000, r.port};
      spp_pkg::REG_STATUS: word = {19'h00000, r.st == spp_pkg::ST_SEND, r.open, r.cnt};
      default: word = 32'h0000_0000;
    endcase
    wval = spp_merge(word, i_wb_dat, i_wb_sel);

    // Bus answer one cycle after the request
    next_r.ack = i_wb_cyc && i_wb_stb && !r.ack;
    if (i_wb_cyc && i_wb_stb && !r.ack) begin
      next_r.rdata = word;
    end
    wr_go = i_wb_cyc && i_wb_stb && r.ack && i_wb_we;
    if (wr_go) begin
      unique case (i_wb_adr)
        spp_pkg::REG_CTRL: begin
          next_r.conn = wval[spp_pkg::CTRL_CONN_LSB +: 3];
          next_r.proc = spp_pkg::spp_proc_t'(wval[spp_pkg::CTRL_PROC_LSB +: 2]);
        end
        spp_pkg::REG_MARK: begin
          next_r.mark1 = wval[7:0];
          next_r.mark2 = wval[spp_pkg::MARK2_LSB +: 8];
        end
        spp_pkg::REG_PKTLEN: next_r.thr = wval[10:0];
        spp_pkg::REG_IDLE: next_r.idle_ms = wval[15:0];
        spp_pkg::REG_INACT: next_r.inact_ms = wval[15:0];
        spp_pkg::REG_PORT: begin
          if (wval[15:0] != 16'h0000) begin
            next_r.port = wval[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ********************************
  // State register
  // ********************************
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r <= RST_VAL;
    end else begin
      r <= next_r;
    end
  end

  // ********************************
  // Checks
  // ********************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  startup_open_a: assert property (
      r.conn == spp_pkg::CONN_STARTUP |=> r.open)
    else $error("startup mode left connection closed");
  char_open_a: assert property (
      accept && r.conn == spp_pkg::CONN_CHAR |=> r.open)
    else $error("first byte did not open connection");
  dsr_close_a: assert property (
      r.conn == spp_pkg::CONN_DSR_OFF && !i_dsr |=> !r.open)
    else $error("DSR off did not close connection");
  dcd_hold_a: assert property (
      r.conn == spp_pkg::CONN_DCD && r.open |=> r.open)
    else $error("DCD on/none mode closed connection");
  thr_flush_a: assert property (
      accept && r.thr != 11'h000 && cnt_n == r.thr && !mk.hit
      |=> r.st == spp_pkg::ST_SEND && r.len == $past(cnt_n))
    else $error("threshold reached without flush");
  thr_off_a: assert property (
      accept && r.thr == 11'h000 && r.mark1 != 8'h00 && !mk.hit &&
      cnt_n != spp_pkg::BUF_FULL
      |=> r.st == spp_pkg::ST_FILL && r.cnt == $past(r.cnt) + 11'h001)
    else $error("byte flushed with no trigger");
  each_byte_a: assert property (
      accept && r.mark1 == 8'h00 |=> r.st == spp_pkg::ST_SEND ##1 r.tvalid)
    else $error("unmarked byte not forwarded");
  full_flush_a: assert property (
      accept && r.cnt == spp_pkg::BUF_FULL - 11'h001 |=> r.st == spp_pkg::ST_SEND)
    else $error("full buffer not flushed");
  idle_flush_a: assert property (
      r.st == spp_pkg::ST_FILL && t_idle |=> r.st == spp_pkg::ST_SEND && r.cnt == 11'h000)
    else $error("idle timeout did not flush");
  idle_off_a: assert property (
      r.idle_ms == 16'h0000 && r.st == spp_pkg::ST_FILL && !accept && r.thr == 11'h000
      |=> r.st == spp_pkg::ST_FILL)
    else $error("idle flush fired while disabled");
  one_frame_a: assert property (
      flush |=> r.cnt == 11'h000 && r.idle == 16'h0000)
    else $error("flush left trigger state behind");
  bus_ack_a: assert property (
      r.ack |=> !r.ack)
    else $error("ack held for two cycles");

  frame_end_c: cover property (r.tvalid && r.tlast && i_tx_ready);
  marker_c: cover property (flush && mk.hit);
  idle_c: cover property (flush && t_idle);
  dcd_drop_c: cover property (r.conn == spp_pkg::CONN_DCD_OFF && r.open ##1 !r.open);
endmodule

//--- test/spp_ser_model.sv
// Serial device and frame sink model facing the packer
`timescale 1ns/1ps
module spp_ser_model (
  // Clock
  input  wire logic       i_clock,
  // Serial byte source
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  input  wire logic       i_rx_ready,
  // Frame sink
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  output logic            o_tx_ready
);
  logic [7:0] got[$];
  int         lens[$];
  int         cnt;
  logic       slow;
  // Idle levels at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'hA5;
    o_tx_ready = 1'b1;
    slow       = 1'b0;
    cnt        = 0;
  end
  // Present each byte and hold it until taken; gaps stay far below the idle time
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_data  <= b[i];
      do begin
        @(posedge i_clock);
      end while (i_rx_ready !== 1'b1);
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~b[i];
    end
  endtask
  // Sink ready, toggling while stalling; capture bytes and frame lengths
  always @(posedge i_clock) begin
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
      got.push_back(i_tx_data);
      cnt++;
      if (i_tx_last === 1'b1) begin
        lens.push_back(cnt);
        cnt = 0;
      end
    end
  end
endmodule

//--- test/testbench.sv
// Self-checking testbench for the serial packet packer
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  logic        i_clock, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic [3:0]  i_wb_sel;
  logic        o_wb_ack, rx_valid, o_rx_ready, i_dsr, i_dcd, i_close_req, i_keepalive_fail;
  logic [7:0]  rx_data, o_tx_data;
  logic        i_dgram_valid, o_dgram_accept, o_conn_open, o_tx_valid, o_tx_last, tx_ready;
  logic [15:0] i_dgram_port, o_listen_port;
  logic [7:0]  big[$];
  int          n_errors, tests_run, cyc_cnt;
  // Device under test with a 10-cycle millisecond tick
  spp_packer #(.TICK_CYCLES(10)) u_dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(o_rx_ready), .i_dsr(i_dsr), .i_dcd(i_dcd), .i_close_req(i_close_req),
    .i_keepalive_fail(i_keepalive_fail), .i_dgram_valid(i_dgram_valid),
    .i_dgram_port(i_dgram_port), .o_dgram_accept(o_dgram_accept),
    .o_listen_port(o_listen_port), .o_conn_open(o_conn_open), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(tx_ready));
  // Serial device and frame sink
  spp_ser_model u_ser (
    .i_clock(i_clock), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(o_rx_ready),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_last(o_tx_last),
    .o_tx_ready(tx_ready));
  // 10 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // Verdict and end of run
  task automatic test_done();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clock) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      n_errors++;
      test_done();
    end
  end
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hF;
    do begin
      @(posedge i_clock);
    end while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  // Configure markers, threshold and process, then check one frame
  task automatic run(input logic [1:0] p, input logic [15:0] m, input logic [10:0] t,
                     input logic [7:0] s[$], input logic [7:0] e[$]);
    wb(1'b1, spp_pkg::REG_CTRL, {26'h0, p, 4'h0});
    wb(1'b1, spp_pkg::REG_MARK, {16'h0, m});
    wb(1'b1, spp_pkg::REG_PKTLEN, {21'h0, t});
    u_ser.send(s);
    chk_frame(e);
  endtask
  // Wait for a frame and compare length and bytes
  task automatic chk_frame(input logic [7:0] e[$]);
    int k;
    logic [31:0] l;
    logic [7:0] g;
    k = 0;
    while (u_ser.lens.size() == 0 && k < 3000) begin
      @(posedge i_clock);
      k++;
    end
    `CHK(u_ser.lens.size() > 0, 1'b1)
    if (u_ser.lens.size() > 0) begin
      l = u_ser.lens.pop_front();
      `CHK(l, e.size())
      foreach (e[i]) begin
        g = u_ser.got.pop_front();
        `CHK(g, e[i])
      end
    end
  endtask
  // Set modem lines and check the connection three cycles later
  task automatic lines(input logic s, input logic c, input logic e);
    i_dsr <= s;
    i_dcd <= c;
    repeat (3) @(posedge i_clock);
    `CHK(o_conn_open, e)
  endtask
  // Pulse a close input and check the connection drops
  task automatic close_pulse(input logic ka);
    i_close_req      <= ~ka;
    i_keepalive_fail <= ka;
    @(posedge i_clock);
    i_close_req      <= 1'b0;
    i_keepalive_fail <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHK(o_conn_open, 1'b0)
  endtask
  // Main sequence
  initial begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_dsr, i_dcd, i_close_req, i_keepalive_fail} = 7'h00;
    {i_dgram_valid, i_wb_adr, i_wb_dat, i_wb_sel, i_dgram_port} = 61'h0;
    {n_errors, tests_run, cyc_cnt} = 96'h0;
    i_sys_rst = 1'b1;
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_clock);
    `CHK(o_listen_port, 16'h0FA1)
    `CHK(o_conn_open, 1'b1)
    wb(1'b0, spp_pkg::REG_PORT, 32'h0);
    `CHK(q, 32'h0000_0FA1)
    wb(1'b0, spp_pkg::REG_PKTLEN, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, spp_pkg::REG_IDLE, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h0)
    i_dgram_valid <= 1'b1;
    i_dgram_port  <= 16'h0FA1;
    @(posedge i_clock);
    `CHK(o_dgram_accept, 1'b1)
    i_dgram_port <= 16'h0FA2;
    @(posedge i_clock);
    `CHK(o_dgram_accept, 1'b0)
    wb(1'b1, spp_pkg::REG_PORT, 32'h1234);
    @(posedge i_clock);
    `CHK(o_listen_port, 16'h1234)
    wb(1'b1, spp_pkg::REG_PORT, 32'h0);
    @(posedge i_clock);
    `CHK(o_listen_port, 16'h1234)
    // Marker packing; the first marker is always set when markers are used
    run(2'h0, 16'h0000, 11'h0, {8'h41, 8'h42}, {8'h41});
    chk_frame({8'h42});
    run(2'h0, 16'h000D, 11'h0, {8'h41, 8'h42, 8'h0D}, {8'h41, 8'h42, 8'h0D});
    run(2'h0, 16'h0A0D, 11'h0, {8'h41, 8'h0D, 8'h42, 8'h0D, 8'h0A},
        {8'h41, 8'h0D, 8'h42, 8'h0D, 8'h0A});
    run(2'h1, 16'h000D, 11'h0, {8'h41, 8'h0D, 8'h42}, {8'h41, 8'h0D, 8'h42});
    run(2'h2, 16'h000D, 11'h0, {8'h41, 8'h0D, 8'h42, 8'h43},
        {8'h41, 8'h0D, 8'h42, 8'h43});
    run(2'h3, 16'h000D, 11'h0, {8'h41, 8'h42, 8'h0D}, {8'h41, 8'h42});
    run(2'h0, 16'h000D, 11'h3, {8'h41, 8'h42, 8'h43}, {8'h41, 8'h42, 8'h43});
    run(2'h0, 16'h000D, 11'h3, {8'h41, 8'h42, 8'h0D}, {8'h41, 8'h42, 8'h0D});
    repeat (20) @(posedge i_clock);
    `CHK(u_ser.lens.size(), 0)
    // Idle flush after 3 ms of silence, restarted by each byte
    wb(1'b1, spp_pkg::REG_PKTLEN, 32'h0);
    wb(1'b1, spp_pkg::REG_IDLE, 32'h3);
    u_ser.send({8'h41});
    repeat (8) @(posedge i_clock);
    `CHK(u_ser.lens.size(), 0)
    repeat (10) @(posedge i_clock);
    u_ser.send({8'h42});
    repeat (15) @(posedge i_clock);
    `CHK(u_ser.lens.size(), 0)
    chk_frame({8'h41, 8'h42});
    wb(1'b1, spp_pkg::REG_IDLE, 32'h0);
    u_ser.send({8'h41});
    repeat (100) @(posedge i_clock);
    `CHK(u_ser.lens.size(), 0)
    wb(1'b0, spp_pkg::REG_STATUS, 32'h0);
    `CHK(q[10:0], 11'h001)
    u_ser.send({8'h0D});
    chk_frame({8'h41, 8'h0D});
    // Full buffer with a stalling sink
    for (int i = 0; i < 1024; i++) big.push_back(8'(i % 200));
    u_ser.slow = 1'b1;
    run(2'h0, 16'h00FF, 11'h0, big, big);
    u_ser.slow = 1'b0;
    wb(1'b0, spp_pkg::REG_STATUS, 32'h0);
    `CHK(q[10:0], 11'h000)
    // Connection control modes
    wb(1'b1, spp_pkg::REG_MARK, 32'h0);
    wb(1'b1, spp_pkg::REG_CTRL, 32'h3);
    lines(1'b1, 1'b0, 1'b1);
    lines(1'b0, 1'b0, 1'b0);
    wb(1'b1, spp_pkg::REG_CTRL, 32'h4);
    lines(1'b1, 1'b0, 1'b1);
    lines(1'b0, 1'b0, 1'b1);
    wb(1'b1, spp_pkg::REG_CTRL, 32'h6);
    lines(1'b0, 1'b1, 1'b1);
    lines(1'b0, 1'b0, 1'b1);
    wb(1'b1, spp_pkg::REG_CTRL, 32'h5);
    lines(1'b0, 1'b1, 1'b1);
    lines(1'b0, 1'b0, 1'b0);
    wb(1'b1, spp_pkg::REG_CTRL, 32'h1);
    lines(1'b0, 1'b0, 1'b0);
    u_ser.send({8'h41});
    lines(1'b0, 1'b0, 1'b1);
    close_pulse(1'b0);
    u_ser.send({8'h42});
    lines(1'b0, 1'b0, 1'b1);
    close_pulse(1'b1);
    wb(1'b1, spp_pkg::REG_INACT, 32'h3);
    wb(1'b1, spp_pkg::REG_CTRL, 32'h2);
    u_ser.send({8'h43});
    lines(1'b0, 1'b0, 1'b1);
    repeat (60) @(posedge i_clock);
    `CHK(o_conn_open, 1'b0)
    test_done();
  end
endmodule
